// ### rtl/les_link_enhance_subsys_regs.sv
/*
 Link enhancement control and subsystem identification register bank.
 Holds the enhancement controls, gates them with the PHY-enhancement bit,
 tracks the transmit threshold across underrun retries and marks which
 transmit streams get the timestamp fix. Assumes an APB master on sys_clk
 and a transmit engine on the same clock reporting underrun and packet done.
*/
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps

module les_link_enhance_subsys_regs
(
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic                        pready,
   output logic [31:0]                 prdata,
   output logic                        pslverr,
   input  wire logic                   txUnderrun,
   input  wire logic                   txPacketDone,
   input  wire logic [5:0]             txCipFormat,
   output les_pkg::les_link_ctl_t      linkCtl,
   output logic                        txTimestampFix,
   output logic                        phyEnhanceGate,
   output logic                        phyProgramAllow
);

   // ****************************************
   // Bus decode
   // ****************************************
   les_pkg::les_apb_req_t req;           // Bundled request
   logic                  access;        // Access phase
   logic                  wrStrobe;      // Write commits this cycle
   logic                  hitEnh;        // Link enhancement offset
   logic                  hitSub;        // Either subsystem location
   logic                  hitHost;       // Host control bits
   logic                  hitRom;        // ROM loader port
   logic                  hitAny;        // Any mapped offset

   assign req      = '{psel, penable, pwrite, paddr, pwdata};
   assign access   = req.psel && req.penable;
   assign pready   = access;             // Zero wait states
   assign wrStrobe = access && req.pwrite;
   assign hitEnh   = req.paddr == les_pkg::LES_OFS_LINK_ENH;
   // Both subsystem offsets hit one store, so the alias cannot drift
   assign hitSub   = (req.paddr == les_pkg::LES_OFS_SUBSYS) ||
                     (req.paddr == les_pkg::LES_OFS_SUBSYS_STD);
   assign hitHost  = req.paddr == les_pkg::LES_OFS_HOST_CTRL;
   assign hitRom   = req.paddr == les_pkg::LES_OFS_EE_LOAD;
   assign hitAny   = hitEnh || hitSub || hitHost || hitRom;
   assign pslverr  = access && !hitAny;  // Unmapped answers with error

   // ****************************************
   // Register storage
   // ****************************************
   logic [31:0] linkEnh;                 // Writable enhancement bits only
   logic [31:0] subsysId;                // Device id high, vendor id low
   logic        gateBit;                 // PHY-enhancement gate
   logic        allowBit;                // Program-PHY allow

   // Link enhancement: software and ROM loader share the same masked path
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         linkEnh <= les_pkg::LES_RST_LINK_ENH;
      else if (wrStrobe && (hitEnh || hitRom))
         // Reserved positions never store anything
         linkEnh <= req.pwdata & les_pkg::LES_LINK_ENH_MASK;
   end

   // Subsystem identification, full word writable
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         subsysId <= les_pkg::LES_RST_SUBSYS;
      else if (wrStrobe && hitSub)
         subsysId <= req.pwdata;
   end

   // Host control bits; ROM image bit 6 lands in the allow bit
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         gateBit  <= 1'b0;
         allowBit <= 1'b0;
      end
      else if (wrStrobe && hitHost)
      begin
         gateBit  <= req.pwdata[les_pkg::LES_BIT_GATE];
         allowBit <= req.pwdata[les_pkg::LES_BIT_PHY_ALLOW];
      end
      else if (wrStrobe && hitRom)
         allowBit <= req.pwdata[les_pkg::LES_BIT_ROM_PHY];
   end

   assign phyEnhanceGate  = gateBit;
   assign phyProgramAllow = allowBit;

   // ****************************************
   // Read path
   // ****************************************
   logic [31:0] next_prdata;             // Read mux

   // Read mux; bit 6 and other reserved bits come back zero from storage
   always_comb
   begin
      next_prdata = 32'h0000_0000;
      if (hitEnh)
         next_prdata = linkEnh;
      else if (hitSub)
         next_prdata = subsysId;
      else if (hitHost)
      begin
         next_prdata[les_pkg::LES_BIT_GATE]      = gateBit;
         next_prdata[les_pkg::LES_BIT_PHY_ALLOW] = allowBit;
      end
   end

   // Read data registered at setup so it is stable in the access phase
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         prdata <= 32'h0000_0000;
      else if (req.psel && !req.penable && !req.pwrite)
         prdata <= next_prdata;
   end

   // ****************************************
   // Threshold tracking
   // ****************************************
   logic        underrunSeen;            // Packet retry pending
   logic [1:0]  threshSel;               // Programmed field
   logic [11:0] next_threshold;          // Decoded threshold

   assign threshSel = linkEnh[les_pkg::LES_BIT_THRESH_LO +: 2];

   // Underrun latches until the retried packet completes; set wins
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         underrunSeen <= 1'b0;
      else if (txUnderrun)
         underrunSeen <= 1'b1;
      else if (txPacketDone)
         underrunSeen <= 1'b0;
   end

   // Decode, with the retry and gate forcing store-and-forward
   always_comb
   begin
      next_threshold = les_pkg::LES_BYTES_2K;
      if (gateBit && !underrunSeen)
         case (threshSel)
            les_pkg::LES_THR_2K  : next_threshold = les_pkg::LES_BYTES_2K;
            les_pkg::LES_THR_1K7 : next_threshold = les_pkg::LES_BYTES_1K7;
            les_pkg::LES_THR_1K  : next_threshold = les_pkg::LES_BYTES_1K;
            les_pkg::LES_THR_512 : next_threshold = les_pkg::LES_BYTES_512;
            default              : next_threshold = les_pkg::LES_BYTES_2K;
         endcase
   end

   // ****************************************
   // Gated enhancement outputs
   // ****************************************
   logic next_tsFix;                     // Timestamp fix decision

   always_comb
   begin
      next_tsFix = 1'b0;
      if (gateBit)
         next_tsFix = (linkEnh[les_pkg::LES_BIT_AUDIO_TS] &&
                       txCipFormat == les_pkg::LES_FMT_AUDIO) ||
                      (linkEnh[les_pkg::LES_BIT_VIDEO_TS] &&
                       txCipFormat == les_pkg::LES_FMT_VIDEO);
   end

   // Registered controls, one cycle behind the register contents
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         linkCtl        <= '{1'b0, 1'b0, 1'b0, les_pkg::LES_BYTES_2K};
         txTimestampFix <= 1'b0;
      end
      else
      begin
         linkCtl.prioReqOn    <= gateBit && linkEnh[les_pkg::LES_BIT_PRIO_REQ];
         linkCtl.idleInsertOn <= gateBit && linkEnh[les_pkg::LES_BIT_IDLE_INS];
         linkCtl.accelOn      <= gateBit && linkEnh[les_pkg::LES_BIT_ACCEL];
         linkCtl.txThreshold  <= next_threshold;
         txTimestampFix       <= next_tsFix;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_enh_write;
      wrStrobe && hitEnh;
   endsequence

   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
      (linkEnh & ~les_pkg::LES_LINK_ENH_MASK) == 32'h0000_0000)
      else $error("reserved bits stored");

   a_gate_off_quiet: assert property (@(posedge sys_clk) disable iff (rst)
      !gateBit |=> !linkCtl.prioReqOn && !linkCtl.idleInsertOn && !linkCtl.accelOn && !txTimestampFix &&
                   linkCtl.txThreshold == les_pkg::LES_BYTES_2K)
      else $error("enhancement active without gate");

   a_retry_store_fwd: assert property (@(posedge sys_clk) disable iff (rst)
      txUnderrun |=> ##1 linkCtl.txThreshold == les_pkg::LES_BYTES_2K)
      else $error("retry threshold not 2K");

   a_thresh_512: assert property (@(posedge sys_clk) disable iff (rst)
      gateBit && !underrunSeen && threshSel == les_pkg::LES_THR_512
      |=> linkCtl.txThreshold == les_pkg::LES_BYTES_512)
      else $error("512 threshold wrong");

   a_audio_fix: assert property (@(posedge sys_clk) disable iff (rst)
      gateBit && linkEnh[les_pkg::LES_BIT_AUDIO_TS] && txCipFormat == les_pkg::LES_FMT_AUDIO
      |=> txTimestampFix)
      else $error("audio fix missing");

   a_video_fix: assert property (@(posedge sys_clk) disable iff (rst)
      gateBit && linkEnh[les_pkg::LES_BIT_VIDEO_TS] && txCipFormat == les_pkg::LES_FMT_VIDEO
      |=> txTimestampFix)
      else $error("video fix missing");

   a_prio_follow: assert property (@(posedge sys_clk) disable iff (rst)
      s_enh_write ##1 (gateBit && !(wrStrobe && (hitEnh || hitRom)))
      |=> linkCtl.prioReqOn == linkEnh[les_pkg::LES_BIT_PRIO_REQ])
      else $error("priority enable not following");

   a_idle_accel: assert property (@(posedge sys_clk) disable iff (rst)
      gateBit |=> linkCtl.idleInsertOn == $past(linkEnh[les_pkg::LES_BIT_IDLE_INS]) &&
                  linkCtl.accelOn == $past(linkEnh[les_pkg::LES_BIT_ACCEL]))
      else $error("idle or accel mismatch");

   a_alias_visible: assert property (@(posedge sys_clk) disable iff (rst)
      wrStrobe && hitSub |=> subsysId == $past(req.pwdata))
      else $error("subsystem alias not written");

   a_rom_phy_bit: assert property (@(posedge sys_clk) disable iff (rst)
      wrStrobe && hitRom |=> allowBit == $past(req.pwdata[les_pkg::LES_BIT_ROM_PHY]) &&
                             !linkEnh[les_pkg::LES_BIT_ROM_PHY])
      else $error("ROM bit 6 misrouted");

   a_retry_hold: assert property (@(posedge sys_clk) disable iff (rst)
      underrunSeen |=> linkCtl.txThreshold == les_pkg::LES_BYTES_2K)
      else $error("retry threshold not held");

   a_thresh_1k7: assert property (@(posedge sys_clk) disable iff (rst)
      gateBit && !underrunSeen && threshSel == les_pkg::LES_THR_1K7
      |=> linkCtl.txThreshold == les_pkg::LES_BYTES_1K7)
      else $error("1.7K threshold wrong");

   a_thresh_1k: assert property (@(posedge sys_clk) disable iff (rst)
      gateBit && !underrunSeen && threshSel == les_pkg::LES_THR_1K
      |=> linkCtl.txThreshold == les_pkg::LES_BYTES_1K)
      else $error("1K threshold wrong");

   // Read setup of the enhancement and subsystem registers; the data must stand by the access phase
   sequence s_rd_enh;
      req.psel && !req.penable && !req.pwrite && hitEnh;
   endsequence

   sequence s_rd_sub;
      req.psel && !req.penable && !req.pwrite && hitSub;
   endsequence

   a_read_enh_zero: assert property (@(posedge sys_clk) disable iff (rst)
      s_rd_enh |=> prdata == $past(linkEnh) &&
                   (prdata & ~les_pkg::LES_LINK_ENH_MASK) == 32'h0000_0000)
      else $error("enhancement read wrong");

   a_read_alias: assert property (@(posedge sys_clk) disable iff (rst)
      s_rd_sub |=> prdata == $past(subsysId))
      else $error("subsystem read wrong");

   a_host_gate: assert property (@(posedge sys_clk) disable iff (rst)
      wrStrobe && hitHost |=> phyEnhanceGate == $past(req.pwdata[les_pkg::LES_BIT_GATE]))
      else $error("gate bit not written");

   // Writes that hit nothing must leave every register alone
   a_unmapped_ignored: assert property (@(posedge sys_clk) disable iff (rst)
      wrStrobe && !hitAny |=> $stable(linkEnh) && $stable(subsysId) && $stable(gateBit) && $stable(allowBit))
      else $error("unmapped write changed state");

endmodule

// ### rtl/les_pkg.sv
/*
 Package for the link enhancement and subsystem identification register bank:
 offsets, field positions, reset values, threshold encodings and bus carriers.
 Assumes a 32-bit APB register bus with byte addresses.
*/
package les_pkg;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] LES_OFS_LINK_ENH  = 8'hF4; // Link enhancement control
   localparam logic [7:0] LES_OFS_SUBSYS    = 8'hF8; // Subsystem id alias
   localparam logic [7:0] LES_OFS_SUBSYS_STD = 8'h2C; // Standard subsystem id location
   localparam logic [7:0] LES_OFS_HOST_CTRL = 8'h80; // Host controller control bits
   localparam logic [7:0] LES_OFS_EE_LOAD   = 8'h84; // Serial ROM loader port

   // ****************************************
   // Field positions
   // ****************************************
   localparam int LES_BIT_THRESH_LO = 12;
   localparam int LES_BIT_AUDIO_TS  = 9;
   localparam int LES_BIT_VIDEO_TS  = 8;
   localparam int LES_BIT_PRIO_REQ  = 7;
   localparam int LES_BIT_ROM_PHY   = 6;
   localparam int LES_BIT_IDLE_INS  = 2;
   localparam int LES_BIT_ACCEL     = 1;
   localparam int LES_BIT_GATE      = 0; // Gate bit in host control register
   localparam int LES_BIT_PHY_ALLOW = 1; // Program-PHY bit in host control register

   // Writable bits of the link enhancement register
   localparam logic [31:0] LES_LINK_ENH_MASK = 32'h0000_3386;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [31:0] LES_RST_LINK_ENH = 32'h0000_1000;
   localparam logic [31:0] LES_RST_SUBSYS   = 32'h0000_0000;

   // ****************************************
   // Threshold encodings and CIP format codes
   // ****************************************
   localparam logic [1:0]  LES_THR_2K   = 2'h0;
   localparam logic [1:0]  LES_THR_1K7  = 2'h1;
   localparam logic [1:0]  LES_THR_1K   = 2'h2;
   localparam logic [1:0]  LES_THR_512  = 2'h3;
   localparam logic [11:0] LES_BYTES_2K  = 12'h800;
   localparam logic [11:0] LES_BYTES_1K7 = 12'h6C0;
   localparam logic [11:0] LES_BYTES_1K  = 12'h400;
   localparam logic [11:0] LES_BYTES_512 = 12'h200;
   localparam logic [5:0]  LES_FMT_AUDIO = 6'h10;
   localparam logic [5:0]  LES_FMT_VIDEO = 6'h00;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed
   {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } les_apb_req_t;

   typedef struct packed
   {
      logic        prioReqOn;    // Asynchronous priority requests
      logic        idleInsertOn; // Idle insertion
      logic        accelOn;      // Acceleration enhancements
      logic [11:0] txThreshold;  // Active transmit threshold in bytes
   } les_link_ctl_t;

endpackage

// ### tb/les_link_enhance_subsys_regs_tb.sv
/*
 Self-checking bench for the link enhancement and subsystem id register bank.
 Assumes the package les_pkg and a zero-wait APB slave on sys_clk.
*/
`timescale 1ns/1ps

module les_link_enhance_subsys_regs_tb;

   // ****************************************
   // Signals and model state
   // ****************************************
   logic                   sys_clk = 1'b0;  // 125 MHz clock
   logic                   rst = 1'b1;      // Async reset, active high
   logic                   psel = 1'b0;
   logic                   penable = 1'b0;
   logic                   pwrite = 1'b0;
   logic [7:0]             paddr = 8'h00;
   logic [31:0]            pwdata = 32'h0;
   logic                   pready;
   logic [31:0]            prdata;
   logic                   pslverr;
   logic                   txUnderrun = 1'b0;   // Underrun pulse
   logic                   txPacketDone = 1'b0; // Packet done pulse
   logic [5:0]             txCipFormat = 6'h00;
   les_pkg::les_link_ctl_t linkCtl;
   logic                   txTimestampFix;
   logic                   phyEnhanceGate;
   logic                   phyProgramAllow;
   int                     seed = 16;       // Fixed seed for repeatable runs
   int                     n_fail = 0;
   int                     check_count = 0;
   logic [31:0]            mEnh = 32'h0000_1000; // Model of the enhancement word
   logic [1:0]             mHost = 2'h0;   // Model: gate bit0, allow bit1
   logic                   mUnder = 1'b0;  // Model: retry after underrun
   logic [31:0]            v;
   logic [31:0]            r;
   logic                   e;

   les_link_enhance_subsys_regs les_link_enhance_subsys_regs_inst
   (
      .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .txUnderrun(txUnderrun), .txPacketDone(txPacketDone), .txCipFormat(txCipFormat),
      .linkCtl(linkCtl), .txTimestampFix(txTimestampFix), .phyEnhanceGate(phyEnhanceGate),
      .phyProgramAllow(phyProgramAllow)
   );

   // Free running clock
   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end

   // ****************************************
   // Compare tasks, one per kind of result
   // ****************************************
   task automatic bump(input logic ok, input string what);
      check_count++;
      if (!ok)
      begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      bump(got === exp, what);
   endtask

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      bump(got === exp, what);
   endtask

   task automatic cmp_ctl(input les_pkg::les_link_ctl_t got, input les_pkg::les_link_ctl_t exp);
      bump(got === exp, "link control outputs");
   endtask

   // ****************************************
   // APB master: holds request until pready seen at an edge
   // ****************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a stuck transfer
      do
      begin
         @(posedge sys_clk);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      apb(1'b0, a, 32'h0);
      cmp_word(r, exp, "read data");
      cmp_bit(e, experr, "slave error");
   endtask

   // Model of the gated link controls
   function automatic les_pkg::les_link_ctl_t exp_ctl();
      logic [11:0] thr;
      thr = (mEnh[13:12] == 2'h0) ? 12'h800 : (mEnh[13:12] == 2'h1) ? 12'h6C0 :
            (mEnh[13:12] == 2'h2) ? 12'h400 : 12'h200;
      if (mUnder)
         thr = 12'h800;
      if (!mHost[0])
         return {3'h0, 12'h800};
      return {mEnh[7], mEnh[2], mEnh[1], thr};
   endfunction

   // Let the outputs settle, then compare all link side results
   task automatic check_link();
      logic fix;
      fix = mHost[0] & ((mEnh[9] & (txCipFormat == 6'h10)) | (mEnh[8] & (txCipFormat == 6'h00)));
      repeat (2) @(posedge sys_clk);
      #1;
      cmp_ctl(linkCtl, exp_ctl());
      cmp_bit(txTimestampFix, fix, "timestamp fix");
      cmp_bit(phyEnhanceGate, mHost[0], "gate");
      cmp_bit(phyProgramAllow, mHost[1], "phy allow");
   endtask

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Watchdog, far beyond the few hundred cycles the run needs
   initial
   begin
      #200000;
      n_fail++;
      tally_and_finish();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      rd_chk(8'hF4, 32'h0000_1000, 1'b0);
      rd_chk(8'hF8, 32'h0, 1'b0);
      rd_chk(8'h2C, 32'h0, 1'b0);
      check_link();
      apb(1'b1, 8'hF4, 32'hFFFF_FFFF);
      mEnh = 32'h0000_3386;
      rd_chk(8'hF4, mEnh, 1'b0);
      // Unmapped write must change nothing and answer with an error
      apb(1'b1, 8'h10, 32'h0000_0000);
      cmp_bit(e, 1'b1, "write error");
      rd_chk(8'h10, 32'h0, 1'b1);
      rd_chk(8'hF4, mEnh, 1'b0);
      // Random controls, every threshold code, formats audio, video and other
      for (int i = 0; i < 12; i++)
      begin
         v = $random(seed);
         v[13:12] = i[1:0];
         apb(1'b1, 8'hF4, v);
         mEnh = v & 32'h0000_3386;
         mHost = {1'b0, i < 10};
         apb(1'b1, 8'h80, {30'h0, mHost});
         txCipFormat <= (i % 3 == 0) ? 6'h10 : (i % 3 == 1) ? 6'h00 : 6'($random(seed));
         rd_chk(8'hF4, mEnh, 1'b0);
         check_link();
      end
      // Subsystem id through either location
      for (int i = 0; i < 4; i++)
      begin
         v = $random(seed);
         apb(1'b1, i[0] ? 8'hF8 : 8'h2C, v);
         rd_chk(i[0] ? 8'h2C : 8'hF8, v, 1'b0);
      end
      // Serial ROM loader image, bit 6 lands in the allow bit
      for (int i = 0; i < 2; i++)
      begin
         v = $random(seed);
         v[6] = i[0];
         apb(1'b1, 8'h84, v);
         mEnh = v & 32'h0000_3386;
         mHost[1] = v[6];
         rd_chk(8'hF4, mEnh, 1'b0);
         rd_chk(8'h84, 32'h0, 1'b0);
         check_link();
      end
      // Underrun retry forces store-and-forward until packet done
      mHost = 2'h1;
      apb(1'b1, 8'h80, 32'h1);
      mEnh = 32'h0000_3000;
      apb(1'b1, 8'hF4, mEnh);
      check_link();
      @(posedge sys_clk);
      txUnderrun <= 1'b1;
      @(posedge sys_clk);
      txUnderrun <= 1'b0;
      mUnder = 1'b1;
      check_link();
      @(posedge sys_clk);
      txPacketDone <= 1'b1;
      @(posedge sys_clk);
      txPacketDone <= 1'b0;
      mUnder = 1'b0;
      check_link();
      tally_and_finish();
   end

endmodule
